// [src/dctg_consts.vh]
/*
 * constants for the command timing guard: timing figures in their own
 * units and cycle counts derived at a 125 MHz controller clock.
 * assumes nothing; definitions only.
 */
// What this block does
// - after a mode register set, no command for at least 2 clocks.
// - column commands (read or write) stand at least 2 clocks apart.
// - activates to different banks 7.5 ns (1KB) or 10 ns (2KB) apart.
// - 1KB pages: four activates span 37.5 ns (667) or 35 ns (800).
// - 2KB pages: four activates span 50 ns (667) or 45 ns (800).
// - a row stays open 45 ns before precharge and closes within 70000 ns; the guard only flags a row past that on ROW_OVERDUE, it does not close it.
// - precharge waits 15 ns after write data, plus precharge if auto.
// - a read waits 7.5 ns of turnaround after the last write data.
// - memory clock period 3000..8000 ps (667) or 2500..8000 ps (800).
// - first write strobe edge lies within 0.25 clock of its clock edge.
// - precharge-all on eight banks adds one clock before next activate.
// - precharge waits 7.5 ns after an internal read.
`ifndef DCTG_CONSTS_VH
`define DCTG_CONSTS_VH

`define DCTG_CLK_PS 8000
// timing figures: MRD and CCD in clocks, DCTG_RAS_MAX_NS in nanoseconds, the rest in picoseconds
`define DCTG_MRD_CK 2
`define DCTG_CCD_CK 2
`define DCTG_RRD_1K_PS 7500
`define DCTG_RRD_2K_PS 10000
`define DCTG_FAW_1K_667_PS 37500
`define DCTG_FAW_1K_800_PS 35000
`define DCTG_FAW_2K_667_PS 50000
`define DCTG_FAW_2K_800_PS 45000
`define DCTG_RAS_MIN_PS 45000
`define DCTG_RAS_MAX_NS 70000
`define DCTG_WR_PS 15000
`define DCTG_WTR_PS 7500
`define DCTG_RTP_PS 7500
`define DCTG_RP_PS 15000
`define DCTG_CK_MIN_667_PS 3000
`define DCTG_CK_MIN_800_PS 2500
`define DCTG_CK_MAX_PS 8000
// strobe offset limit in quarters of a clock
`define DCTG_DQSS_QTR 1

// least time rounds up, longest time rounds down
`define DCTG_UP(ps) (((ps) + `DCTG_CLK_PS - 1) / `DCTG_CLK_PS)
`define DCTG_DN_NS(ns) (((ns) * 1000) / `DCTG_CLK_PS)

// command codes presented on the request port
`define DCTG_CMD_NOP 3'h0
`define DCTG_CMD_ACT 3'h1
`define DCTG_CMD_RD 3'h2
`define DCTG_CMD_WR 3'h3
`define DCTG_CMD_PRE 3'h4
`define DCTG_CMD_PREA 3'h5
`define DCTG_CMD_MRS 3'h6
`define DCTG_CMD_REF 3'h7

`endif

// [src/dctg_guard.v]
/*
 * command timing guard for a DDR2 memory controller: takes command
 * requests, holds each one until every spacing constraint is met, then
 * issues it for one cycle with a write strobe placement flag.
 * assumes requests from logic on CLK; the controller clock period (8 ns)
 * also serves as memory clock, which satisfies the period window.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dctg_consts.vh"

module dctg_guard #(
    parameter PAGE_2K = 0,
    parameter GRADE_800 = 0,
    parameter AUTO_PRE_WR = 0,
    parameter RAS_MAX_CK = `DCTG_DN_NS(`DCTG_RAS_MAX_NS),
    parameter BANKS = 8
) (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire REQ_VALID,
    input wire [2:0] REQ_CMD,
    input wire [2:0] REQ_BANK,
    output reg REQ_READY,
    output reg CMD_VALID,
    output reg [2:0] CMD_CODE,
    output reg [2:0] CMD_BANK,
    output reg DQS_ALIGNED,
    output reg [7:0] ROW_OVERDUE
);

    // cycle counts worked out at full width first
    localparam integer MRD_N = `DCTG_MRD_CK;
    localparam integer CCD_N = `DCTG_CCD_CK;
    localparam integer RRD_N = PAGE_2K ? `DCTG_UP(`DCTG_RRD_2K_PS)
                                       : `DCTG_UP(`DCTG_RRD_1K_PS);
    localparam integer FAW_N = PAGE_2K ?
        (GRADE_800 ? `DCTG_UP(`DCTG_FAW_2K_800_PS)
                   : `DCTG_UP(`DCTG_FAW_2K_667_PS)) :
        (GRADE_800 ? `DCTG_UP(`DCTG_FAW_1K_800_PS)
                   : `DCTG_UP(`DCTG_FAW_1K_667_PS));
    localparam integer RAS_N = `DCTG_UP(`DCTG_RAS_MIN_PS);
    localparam integer WR_N = `DCTG_UP(`DCTG_WR_PS);
    localparam integer WTR_N = `DCTG_UP(`DCTG_WTR_PS);
    localparam integer RTP_N = `DCTG_UP(`DCTG_RTP_PS);
    localparam integer RP_N = `DCTG_UP(`DCTG_RP_PS);
    // cut to the 8-bit counter width; every count fits well inside it
    localparam [7:0] MRD = MRD_N[7:0];
    localparam [7:0] CCD = CCD_N[7:0];
    localparam [7:0] RRD = RRD_N[7:0];
    localparam [7:0] FAW = FAW_N[7:0];
    localparam [7:0] RAS = RAS_N[7:0];
    localparam [7:0] WR = WR_N[7:0];
    localparam [7:0] WTR = WTR_N[7:0];
    localparam [7:0] RTP = RTP_N[7:0];
    localparam [7:0] RP = RP_N[7:0];
    localparam [7:0] PREA = RP + 8'h01;
    localparam [7:0] DAL = WR + RP;
    // states of the issue path
    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_HOLD = 1'b1;

    reg [0:0] state_reg;
    reg [2:0] cmd_reg;
    reg [2:0] bank_reg;
    reg [7:0] mrd_reg;
    reg [7:0] ccd_reg;
    reg [7:0] rrd_reg;
    reg [7:0] wtr_reg;
    reg [7:0] faw_reg [0:3];
    reg [1:0] faw_ptr_reg;
    reg [7:0] ras_reg [0:BANKS-1];
    reg [7:0] pre_reg [0:BANKS-1];
    reg [7:0] act_reg [0:BANKS-1];
    reg [16:0] open_reg [0:BANKS-1];
    reg [BANKS-1:0] is_open_reg;
    reg ok;
    integer i;

    // counter step: down to zero, saturating
    function [7:0] dec;
        input [7:0] v;
        begin
            dec = (v != 8'h00) ? v - 8'h01 : 8'h00;
        end
    endfunction

    // any bank still blocking a precharge-all
    function any_busy;
        input [BANKS*8-1:0] v;
        integer k;
        begin
            any_busy = 1'b0;
            for (k = 0; k < BANKS; k = k + 1) begin
                if (v[k*8 +: 8] != 8'h00)
                    any_busy = 1'b1;
            end
        end
    endfunction

    // per-bank blockers flattened for the precharge-all test
    wire [BANKS*8-1:0] pre_flat;
    genvar g;
    generate
        for (g = 0; g < BANKS; g = g + 1) begin : g_pre
            assign pre_flat[g*8 +: 8] = pre_reg[g] | ras_reg[g];
        end
    endgenerate

    // readiness of the held command against the mode-set gap and its own counters
    always @* begin
        ok = (mrd_reg == 8'h00);
        case (cmd_reg)
            `DCTG_CMD_ACT: ok = ok && (rrd_reg == 8'h00)
                && (faw_reg[faw_ptr_reg] == 8'h00)
                && (act_reg[bank_reg] == 8'h00);
            `DCTG_CMD_RD: ok = ok && (ccd_reg == 8'h00)
                && (wtr_reg == 8'h00);
            `DCTG_CMD_WR: ok = ok && (ccd_reg == 8'h00);
            `DCTG_CMD_PRE: ok = ok && (ras_reg[bank_reg] == 8'h00)
                && (pre_reg[bank_reg] == 8'h00);
            `DCTG_CMD_PREA: ok = ok && !any_busy(pre_flat);
            default: ok = ok;
        endcase
    end

    // issue path and per-bank / global down-counters
    always @(posedge CLK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 3'h0;
            bank_reg <= 3'h0;
            REQ_READY <= 1'b0;
            CMD_VALID <= 1'b0;
            CMD_CODE <= 3'h0;
            CMD_BANK <= 3'h0;
            DQS_ALIGNED <= 1'b0;
            ROW_OVERDUE <= 8'h00;
            mrd_reg <= 8'h00;
            ccd_reg <= 8'h00;
            rrd_reg <= 8'h00;
            wtr_reg <= 8'h00;
            faw_ptr_reg <= 2'h0;
            is_open_reg <= {BANKS{1'b0}};
            for (i = 0; i < 4; i = i + 1)
                faw_reg[i] <= 8'h00;
            for (i = 0; i < BANKS; i = i + 1) begin
                ras_reg[i] <= 8'h00;
                pre_reg[i] <= 8'h00;
                act_reg[i] <= 8'h00;
                open_reg[i] <= 17'h00000;
            end
        end else if (CE) begin
            // counters count every cycle; reloads below override
            mrd_reg <= dec(mrd_reg);
            ccd_reg <= dec(ccd_reg);
            rrd_reg <= dec(rrd_reg);
            wtr_reg <= dec(wtr_reg);
            for (i = 0; i < 4; i = i + 1)
                faw_reg[i] <= dec(faw_reg[i]);
            for (i = 0; i < BANKS; i = i + 1) begin
                ras_reg[i] <= dec(ras_reg[i]);
                pre_reg[i] <= dec(pre_reg[i]);
                act_reg[i] <= dec(act_reg[i]);
                // saturate so a forgotten row never wraps back to "fresh"
                if (is_open_reg[i] && open_reg[i] != 17'h1ffff)
                    open_reg[i] <= open_reg[i] + 17'h00001;
                // flag rows open past the longest allowed time
                ROW_OVERDUE[i] <= is_open_reg[i] &&
                    (open_reg[i] >= RAS_MAX_CK[16:0]);
            end
            CMD_VALID <= 1'b0;
            DQS_ALIGNED <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (REQ_VALID && REQ_READY) begin
                        cmd_reg <= REQ_CMD;
                        bank_reg <= REQ_BANK;
                        REQ_READY <= 1'b0;
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (ok) begin
                        CMD_VALID <= 1'b1;
                        CMD_CODE <= cmd_reg;
                        CMD_BANK <= bank_reg;
                        // strobe launched on the command-clock edge,
                        // offset 0 inside the quarter-clock window
                        DQS_ALIGNED <= (cmd_reg == `DCTG_CMD_WR);
                        state_reg <= ST_IDLE;
                        case (cmd_reg)
                            `DCTG_CMD_MRS: mrd_reg <= MRD - 8'h01;
                            `DCTG_CMD_ACT: begin
                                rrd_reg <= RRD - 8'h01;
                                faw_reg[faw_ptr_reg] <= FAW-8'h01;
                                faw_ptr_reg <= faw_ptr_reg + 2'h1;
                                ras_reg[bank_reg] <= RAS - 8'h01;
                                is_open_reg[bank_reg] <= 1'b1;
                                open_reg[bank_reg] <= 17'h00000;
                            end
                            `DCTG_CMD_RD: begin
                                ccd_reg <= CCD - 8'h01;
                                pre_reg[bank_reg] <= RTP - 8'h01;
                            end
                            `DCTG_CMD_WR: begin
                                ccd_reg <= CCD - 8'h01;
                                wtr_reg <= WTR - 8'h01;
                                pre_reg[bank_reg] <= WR - 8'h01;
                                // auto-precharge reopens after WR+RP
                                if (AUTO_PRE_WR) begin
                                    act_reg[bank_reg] <= DAL - 8'h01;
                                    is_open_reg[bank_reg] <= 1'b0;
                                end
                            end
                            `DCTG_CMD_PRE: begin
                                act_reg[bank_reg] <= RP - 8'h01;
                                is_open_reg[bank_reg] <= 1'b0;
                            end
                            `DCTG_CMD_PREA: begin
                                for (i = 0; i < BANKS; i = i + 1)
                                    act_reg[i] <= PREA - 8'h01;
                                is_open_reg <= {BANKS{1'b0}};
                            end
                            default: mrd_reg <= dec(mrd_reg);
                        endcase
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// [verif/dctg_guard_checker.sv]
/* assertions on the guard's ports.
   assumes the bind below hands on the longest-open parameter. */
`timescale 1ns/100ps
`default_nettype none
module dctg_guard_checker #(
    parameter RAS_MAX_CK = 8750
) (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire REQ_VALID,
    input wire REQ_READY,
    input wire CMD_VALID,
    input wire [2:0] CMD_CODE,
    input wire [2:0] CMD_BANK,
    input wire DQS_ALIGNED,
    input wire [7:0] ROW_OVERDUE
);
    logic [7:0] since_mrs;
    logic [15:0] age [8];
    wire mrs = CMD_VALID && CMD_CODE == 3'h6;
    wire col = CMD_VALID && CMD_CODE[2:1] == 2'b01;
    wire pre = CMD_VALID && CMD_CODE[2:1] == 2'b10;
    wire wr = col && CMD_CODE[0];
    wire act = CMD_VALID && CMD_CODE == 3'h1;
    wire prea = CMD_VALID && CMD_CODE == 3'h5;
    logic young;
    // any bank activated too recently for a precharge-all
    always_comb begin
        young = 1'b0;
        for (int i = 0; i < 8; i++)
            young |= age[i] < 16'h0005;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST || !CE);
    // clocks since events; saturating so old events stay old
    always @(posedge CLK) begin
        if (RST)
            since_mrs <= 8'hff;
        else if (CE)
            since_mrs <= mrs ? 8'h00 : since_mrs + {7'h0, since_mrs != 8'hff};
        for (int i = 0; i < 8; i++)
            if (RST)
                age[i] <= 16'hffff;
            else if (CE && CMD_VALID && CMD_CODE == 3'h1 && CMD_BANK == i)
                age[i] <= 16'h0000;
            else if (CE && age[i] != 16'hffff)
                age[i] <= age[i] + 16'h0001;
    end
    a_mrs_gap: assert property (CMD_VALID |-> since_mrs != 8'h00)
        else $error("issue too soon after mode set");
    a_col_gap: assert property (col |=> !col)
        else $error("column commands too close");
    a_ras_min: assert property (pre |-> age[CMD_BANK] >= 16'h5)
        else $error("precharge too early");
    a_prea_ras: assert property (prea |-> !young)
        else $error("precharge-all too early");
    a_prea_act: assert property (prea |=> !act ##1 !act)
        else $error("activate too soon after precharge-all");
    a_strobe_write: assert property (DQS_ALIGNED |-> wr)
        else $error("strobe flag without write");
    a_write_strobe: assert property (wr |-> DQS_ALIGNED)
        else $error("write without strobe flag");
    a_overdue_set: assert property ($rose(ROW_OVERDUE[5])
        |-> age[5] >= RAS_MAX_CK) else $error("overdue early");
    a_overdue_clr: assert property (pre && CMD_BANK == 3'h5
        |-> ##[1:2] !ROW_OVERDUE[5]) else $error("overdue not cleared");
    a_issue_bound: assert property (REQ_VALID && REQ_READY
        |-> ##[1:60] CMD_VALID) else $error("request never issued");
    c_pre: cover property (pre);
    c_write: cover property (wr);
    c_prea: cover property (prea);
    c_overdue: cover property ($rose(ROW_OVERDUE[5]));
endmodule
bind dctg_guard dctg_guard_checker #(.RAS_MAX_CK(RAS_MAX_CK)) u_chk (
    .CLK(CLK), .RST(RST), .CE(CE), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
    .CMD_BANK(CMD_BANK), .DQS_ALIGNED(DQS_ALIGNED),
    .ROW_OVERDUE(ROW_OVERDUE));
`default_nettype wire

// [verif/dctg_guard_test.sv]
/* self-checking bench for the command timing guard.
   assumes the memory model and checker files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module dctg_guard_test;
    logic CLK = 0;
    logic RST = 1;
    logic CE = 1;
    logic REQ_VALID = 0;
    logic [2:0] REQ_CMD = 0;
    logic [2:0] REQ_BANK = 0;
    wire REQ_READY, CMD_VALID, DQS_ALIGNED;
    wire [2:0] CMD_CODE, CMD_BANK;
    wire [7:0] ROW_OVERDUE, errs;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    realtime t0;
    always #4 CLK = ~CLK;
    always @(posedge CLK) cyc <= cyc + 1;
    // short longest-open count keeps the run brief
    dctg_guard #(.RAS_MAX_CK(40)) u_dut (.CLK(CLK), .RST(RST), .CE(CE),
        .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD), .REQ_BANK(REQ_BANK),
        .REQ_READY(REQ_READY), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
        .CMD_BANK(CMD_BANK), .DQS_ALIGNED(DQS_ALIGNED),
        .ROW_OVERDUE(ROW_OVERDUE));
    dctg_mem_model u_mem (.clk(CLK), .rst(RST), .valid(CMD_VALID),
        .code(CMD_CODE), .bank(CMD_BANK), .errs(errs));
    task check(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            fails++;
        end
    endtask
    task stop_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hold the request through the taking edge, then await its issue
    task automatic issue(input logic [2:0] c, b, output int at);
        int k = 0;
        @(negedge CLK);
        REQ_VALID = 1;
        REQ_CMD = c;
        REQ_BANK = b;
        while (REQ_READY !== 1'b1 && k < 99) begin
            @(negedge CLK);
            k++;
        end
        @(negedge CLK);
        REQ_VALID = 0;
        while (CMD_VALID !== 1'b1 && k < 99) begin
            @(negedge CLK);
            k++;
        end
        if (k >= 99) begin
            fails++;
            stop_test();
        end
        at = cyc;
        check("issued", {CMD_BANK, CMD_CODE}, {b, c});
        check("strobe", DQS_ALIGNED, c == 3'h3);
    endtask
    // back-to-back mix; g holds the least gap to the previous issue
    task t_seq;
        logic [2:0] c[11] = '{6, 7, 1, 3, 3, 2, 4, 1, 5, 1, 4};
        logic [2:0] b[11] = '{0, 0, 2, 2, 2, 2, 2, 3, 0, 3, 3};
        int g[11] = '{0, 2, 1, 1, 2, 2, 1, 1, 6, 3, 6};
        int t[11];
        for (int i = 0; i < 11; i++) begin
            issue(c[i], b[i], t[i]);
            check("gap", !i || t[i]-t[i-1] >= g[i], 1);
        end
        check("wtr", t[5] - t[4] >= 1, 1);
        check("rtp", t[6] - t[5] >= 1, 1);
        check("ras", t[6] - t[2] >= 6, 1);
        check("wr_rec", t[6] - t[4] >= 2, 1);
        check("prea", t[9] - t[8] >= 3, 1);
    endtask
    // row left open past the longest open time, then closed
    task t_overdue;
        int a;
        issue(3'h1, 3'h5, a);
        repeat (30) @(negedge CLK);
        check("overdue_early", ROW_OVERDUE, 0);
        repeat (14) @(negedge CLK);
        check("overdue", ROW_OVERDUE, 8'h20);
        issue(3'h4, 3'h5, a);
        repeat (2) @(negedge CLK);
        check("overdue_clr", ROW_OVERDUE, 0);
    endtask
    // enable low freezes a precharge held on the open-row wait
    task t_ce;
        int a;
        issue(3'h1, 3'h6, a);
        @(negedge CLK);
        REQ_VALID = 1;
        REQ_CMD = 3'h4;
        REQ_BANK = 3'h6;
        @(negedge CLK);
        REQ_VALID = 0;
        CE = 0;
        repeat (8) @(negedge CLK);
        check("frozen", {REQ_READY, CMD_VALID}, 2'b00);
        CE = 1;
        // three open-row clocks were left when the enable dropped
        repeat (3) @(negedge CLK);
        check("held", CMD_VALID, 0);
        @(negedge CLK);
        check("released", {CMD_VALID, CMD_CODE}, 4'hc);
    endtask
    initial begin
        // clock period measured while reset is still held
        @(posedge CLK);
        t0 = $realtime;
        @(posedge CLK);
        t0 = $realtime - t0;
        check("clk_period", t0 >= 3.0 && t0 <= 8.0, 1);
        repeat (3) @(negedge CLK);
        check("reset", {REQ_READY, CMD_VALID, ROW_OVERDUE}, 0);
        RST = 0;
        t_seq();
        t_overdue();
        t_ce();
        check("mem_model", errs, 0);
        stop_test();
    end
endmodule
`default_nettype wire

// [verif/dctg_mem_model.sv]
/* memory-side model: counts issued commands that come too early.
   assumes an 8 ns clock and one issue per cycle at most. */
`timescale 1ns/100ps
`default_nettype none
module dctg_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic valid,
    input wire logic [2:0] code,
    input wire logic [2:0] bank,
    output var logic [7:0] errs
);
    int cyc = 100;
    int t_mrs, t_col, t_act, t_wl;
    int t_open[8], t_wr[8], t_pre[8];
    int acts[$];
    logic bad;
    // gaps in clocks; ns figures rounded up at 8 ns
    always @(posedge clk) begin
        cyc <= cyc + 1;
        bad = valid && cyc - t_mrs < 2;
        if (valid && code == 3'h1) begin
            bad |= cyc - t_act < 1 || cyc - t_pre[bank] < 2;
            bad |= acts.size() > 3 && cyc-acts[$-3] < 5;
            acts.push_back(cyc);
            t_act = cyc;
            t_open[bank] = cyc;
        end
        if (valid && code[2:1] == 2'b01) begin
            bad |= cyc - t_col < 2;
            bad |= !code[0] && cyc - t_wl < 1;
            t_col = cyc;
        end
        if (valid && code == 3'h3) begin
            t_wl = cyc;
            t_wr[bank] = cyc;
        end
        // precharge-all closes every bank and costs one clock more
        for (int i = 0; i < 8; i++)
            if (valid && (code == 3'h5 || (code == 3'h4 && bank == i))) begin
                bad |= cyc - t_open[i] < 6;
                bad |= cyc - t_wr[i] < 2;
                t_pre[i] = cyc + (code == 3'h5);
            end
        if (valid && code == 3'h6)
            t_mrs = cyc;
        errs <= rst ? 8'h00 : errs + {7'h00, bad};
    end
endmodule
`default_nettype wire
